// File: rtl/pin_ctrl_pkg.sv
package pin_ctrl_pkg;
  // port widths
  localparam int KEYPAD_W = 8;
  localparam int CONV_W = 8;
  localparam int DRIVE_W = 7;
  localparam int PERIPH_W = 8;
  localparam int SERIAL_W = 6;
  // field positions on the peripheral port
  localparam int SPI_LO = 0;
  localparam int SPI_HI = 3;
  localparam int TIM_LO = 4;
  // serial port positions
  localparam int TX_BIT = 0;
  localparam int RX_BIT = 1;
  // reset values
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  // cycles the reset pin is driven low after an internal source drops
  localparam int RST_STRETCH_CYC = 4;
  localparam int STRETCH_W = 3;
  // reset pin driver states, gray from RP_IDLE through RP_DRIVE to RP_HOLD; two bits change from RP_HOLD back to RP_IDLE
  typedef enum logic [1:0]
  {
    RP_IDLE = 2'b00,
    RP_DRIVE = 2'b01,
    RP_HOLD = 2'b11
  } rst_pin_state_t;
endpackage

// File: rtl/pin_cell.sv
`timescale 1ns/1ps
// one pin: port/peripheral mux with gated pullup
module pin_cell (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic gp_dir,
  input wire logic gp_data,
  input wire logic pu_sel,
  input wire logic fn_en,
  input wire logic fn_oe,
  input wire logic fn_out,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic pullup_en,
  output logic pin_sync
);
  logic s1;
  logic next_oe;
  logic next_out;
  // peripheral takes direction and level when enabled
  // function overrides port
  assign next_oe = fn_en ? fn_oe : gp_dir;
  assign next_out = fn_en ? fn_out : gp_data;
  // registered pin drive and pullup; input synchroniser
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_oe <= 1'b0;
      pin_out <= 1'b0;
      pullup_en <= 1'b0;
      s1 <= 1'b0;
      pin_sync <= 1'b0;
    end
    else
    begin
      pin_oe <= next_oe;
      pin_out <= next_out;
      pullup_en <= pu_sel & ~next_oe;
      s1 <= pin_in;
      pin_sync <= s1;
    end
  end
  AST_PU_OFF_OUT: assert property (@(posedge mclk) disable iff (!rst_n)
    pin_oe |-> !pullup_en) else $error("pullup on while driving");
  AST_FN_DIR: assert property (@(posedge mclk) disable iff (!rst_n)
    fn_en |=> pin_oe == $past(fn_oe)) else $error("function lost direction");
endmodule

// File: rtl/port_pin_function_control.sv
`timescale 1ns/1ps
module port_pin_function_control #(
  parameter int KW = pin_ctrl_pkg::KEYPAD_W,
  parameter int CW = pin_ctrl_pkg::CONV_W,
  parameter int HW = pin_ctrl_pkg::DRIVE_W,
  parameter int PW = pin_ctrl_pkg::PERIPH_W,
  parameter int SW = pin_ctrl_pkg::SERIAL_W
) (
  input wire logic mclk,
  input wire logic rst_n,
  // keypad port
  input wire logic [KW-1:0] keypad_dir,
  input wire logic [KW-1:0] keypad_data,
  input wire logic [KW-1:0] keypad_pullup_sel,
  input wire logic [KW-1:0] keypad_wakeup_en,
  input wire logic [KW-1:0] keypad_port_pins_in,
  output logic [KW-1:0] keypad_port_pins_out,
  output logic [KW-1:0] keypad_port_pins_oe,
  output logic [KW-1:0] keypad_pullup_en,
  output logic [KW-1:0] keypad_port_value,
  output logic [KW-1:0] keypad_wakeup_module_in,
  // converter port
  input wire logic [CW-1:0] conv_dir,
  input wire logic [CW-1:0] conv_data,
  input wire logic [CW-1:0] conv_analog_en,
  input wire logic [CW-1:0] converter_port_pins_in,
  output logic [CW-1:0] converter_port_pins_out,
  output logic [CW-1:0] converter_port_pins_oe,
  output logic [CW-1:0] conv_digital_in_en,
  output logic [CW-1:0] conv_port_value,
  // high drive port
  input wire logic [HW-1:0] drive_dir,
  input wire logic [HW-1:0] drive_data,
  input wire logic [HW-1:0] drive_pullup_sel,
  input wire logic [HW-1:0] high_drive_port_pins_in,
  output logic [HW-1:0] high_drive_port_pins_out,
  output logic [HW-1:0] high_drive_port_pins_oe,
  output logic [HW-1:0] drive_pullup_en,
  output logic [HW-1:0] drive_port_value,
  // peripheral port
  input wire logic [PW-1:0] periph_dir,
  input wire logic [PW-1:0] periph_data,
  input wire logic [PW-1:0] periph_pullup_sel,
  input wire logic spi_en,
  input wire logic [3:0] spi_oe,
  input wire logic [3:0] spi_out,
  input wire logic [3:0] timer_ch_en,
  input wire logic [3:0] timer_unit_sel,
  input wire logic [1:0] first_timer_unit_oe,
  input wire logic [1:0] first_timer_unit_out,
  input wire logic [1:0] second_timer_unit_oe,
  input wire logic [1:0] second_timer_unit_out,
  input wire logic [PW-1:0] peripheral_port_pins_in,
  output logic [PW-1:0] peripheral_port_pins_out,
  output logic [PW-1:0] peripheral_port_pins_oe,
  output logic [PW-1:0] periph_pullup_en,
  output logic [PW-1:0] periph_port_value,
  // serial port
  input wire logic [SW-1:0] serial_dir,
  input wire logic [SW-1:0] serial_data,
  input wire logic serial_en,
  input wire logic async_tx,
  input wire logic [SW-1:0] serial_port_pins_in,
  output logic [SW-1:0] serial_port_pins_out,
  output logic [SW-1:0] serial_port_pins_oe,
  output logic [SW-1:0] serial_port_value,
  output logic async_rx,
  // reset pin and interrupt pin
  input wire logic internal_reset_req,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic ext_reset_req,
  input wire logic irq_pin_n,
  input wire logic irq_ack,
  output logic irq_pending
);
  import pin_ctrl_pkg::*;

  // peripheral function mux selects for the peripheral and serial ports
  logic [PW-1:0] pd_fn_en;
  logic [PW-1:0] pd_fn_oe;
  logic [PW-1:0] pd_fn_out;
  logic [SW-1:0] pe_fn_en;
  logic [SW-1:0] pe_fn_oe;
  logic [SW-1:0] pe_fn_out;
  logic [CW-1:0] pb_dir_eff;
  logic [KW-1:0] ka_sync;
  logic [SW-1:0] se_sync;

  assign pd_fn_en[SPI_HI:SPI_LO] = {4{spi_en}};
  assign pd_fn_oe[SPI_HI:SPI_LO] = spi_oe;
  assign pd_fn_out[SPI_HI:SPI_LO] = spi_out;
  assign pd_fn_en[PW-1:TIM_LO] = timer_ch_en;
  assign pd_fn_oe[PW-1:TIM_LO] = {
    timer_unit_sel[3] ? second_timer_unit_oe[1] : first_timer_unit_oe[1],
    timer_unit_sel[2] ? second_timer_unit_oe[0] : first_timer_unit_oe[0],
    timer_unit_sel[1] ? second_timer_unit_oe[1] : first_timer_unit_oe[1],
    timer_unit_sel[0] ? second_timer_unit_oe[0] : first_timer_unit_oe[0]};
  assign pd_fn_out[PW-1:TIM_LO] = {
    timer_unit_sel[3] ? second_timer_unit_out[1] : first_timer_unit_out[1],
    timer_unit_sel[2] ? second_timer_unit_out[0] : first_timer_unit_out[0],
    timer_unit_sel[1] ? second_timer_unit_out[1] : first_timer_unit_out[1],
    timer_unit_sel[0] ? second_timer_unit_out[0] : first_timer_unit_out[0]};
  assign pe_fn_en = {{(SW-2){1'b0}}, serial_en, serial_en};
  assign pe_fn_oe = {{(SW-2){1'b0}}, 1'b0, 1'b1};
  assign pe_fn_out = {{(SW-2){1'b0}}, 1'b0, async_tx};
  assign pb_dir_eff = conv_dir & ~conv_analog_en;

  // per-pin cells; keypad, high drive and peripheral bits each their own pullup, converter and serial none
  genvar g;
  generate
    for (g = 0; g < KW; g++)
    begin : g_ka
      pin_cell u_cell (
        .mclk(mclk), .rst_n(rst_n), .gp_dir(keypad_dir[g]), .gp_data(keypad_data[g]),
        .pu_sel(keypad_pullup_sel[g]), .fn_en(1'b0), .fn_oe(1'b0), .fn_out(1'b0),
        .pin_in(keypad_port_pins_in[g]), .pin_out(keypad_port_pins_out[g]),
        .pin_oe(keypad_port_pins_oe[g]), .pullup_en(keypad_pullup_en[g]),
        .pin_sync(ka_sync[g]));
    end
    for (g = 0; g < CW; g++)
    begin : g_cb
      pin_cell u_cell (
        .mclk(mclk), .rst_n(rst_n), .gp_dir(pb_dir_eff[g]), .gp_data(conv_data[g]),
        .pu_sel(1'b0), .fn_en(1'b0), .fn_oe(1'b0), .fn_out(1'b0),
        .pin_in(converter_port_pins_in[g]), .pin_out(converter_port_pins_out[g]),
        .pin_oe(converter_port_pins_oe[g]), .pullup_en(),
        .pin_sync(conv_port_value[g]));
    end
    for (g = 0; g < HW; g++)
    begin : g_hd
      pin_cell u_cell (
        .mclk(mclk), .rst_n(rst_n), .gp_dir(drive_dir[g]), .gp_data(drive_data[g]),
        .pu_sel(drive_pullup_sel[g]), .fn_en(1'b0), .fn_oe(1'b0), .fn_out(1'b0),
        .pin_in(high_drive_port_pins_in[g]), .pin_out(high_drive_port_pins_out[g]),
        .pin_oe(high_drive_port_pins_oe[g]), .pullup_en(drive_pullup_en[g]),
        .pin_sync(drive_port_value[g]));
    end
    for (g = 0; g < PW; g++)
    begin : g_pd
      pin_cell u_cell (
        .mclk(mclk), .rst_n(rst_n), .gp_dir(periph_dir[g]), .gp_data(periph_data[g]),
        .pu_sel(periph_pullup_sel[g]), .fn_en(pd_fn_en[g]), .fn_oe(pd_fn_oe[g]),
        .fn_out(pd_fn_out[g]), .pin_in(peripheral_port_pins_in[g]),
        .pin_out(peripheral_port_pins_out[g]), .pin_oe(peripheral_port_pins_oe[g]),
        .pullup_en(periph_pullup_en[g]), .pin_sync(periph_port_value[g]));
    end
    for (g = 0; g < SW; g++)
    begin : g_se
      pin_cell u_cell (
        .mclk(mclk), .rst_n(rst_n), .gp_dir(serial_dir[g]), .gp_data(serial_data[g]),
        .pu_sel(1'b0), .fn_en(pe_fn_en[g]), .fn_oe(pe_fn_oe[g]), .fn_out(pe_fn_out[g]),
        .pin_in(serial_port_pins_in[g]), .pin_out(serial_port_pins_out[g]),
        .pin_oe(serial_port_pins_oe[g]), .pullup_en(), .pin_sync(se_sync[g]));
    end
  endgenerate

  // synchronised pin values to port readback and peripherals
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      keypad_port_value <= DATA_RST;
      keypad_wakeup_module_in <= DATA_RST;
      conv_digital_in_en <= {CW{1'b1}};
      serial_port_value <= '0;
      async_rx <= 1'b1;
    end
    else
    begin
      keypad_port_value <= ka_sync;
      keypad_wakeup_module_in <= ka_sync & keypad_wakeup_en;
      conv_digital_in_en <= ~conv_analog_en;
      serial_port_value <= se_sync;
      async_rx <= serial_en ? se_sync[RX_BIT] : 1'b1;
    end
  end

  // reset pin: synchroniser on the pin input, stretch on internal sources
  rst_pin_state_t rp_state;
  rst_pin_state_t next_rp_state;
  logic [STRETCH_W-1:0] stretch;
  logic rp_s1;
  logic rp_s2;
  logic own_drive_d1;
  logic own_drive_d2;
  logic rq_s1;
  logic rq_s2;
  logic rq_s3;
  always_comb
  begin
    next_rp_state = rp_state;
    case (rp_state)
      RP_IDLE: if (internal_reset_req) next_rp_state = RP_DRIVE;
      RP_DRIVE: if (!internal_reset_req) next_rp_state = RP_HOLD;
      RP_HOLD:
        if (internal_reset_req) next_rp_state = RP_DRIVE;
        else if (stretch == STRETCH_W'(RST_STRETCH_CYC - 1)) next_rp_state = RP_IDLE;
      default: next_rp_state = RP_IDLE;
    endcase
  end
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rp_state <= RP_IDLE;
      stretch <= '0;
      reset_pin_out <= 1'b0;
      reset_pin_oe <= 1'b0;
      rp_s1 <= 1'b1;
      rp_s2 <= 1'b1;
      own_drive_d1 <= 1'b0;
      own_drive_d2 <= 1'b0;
      ext_reset_req <= 1'b0;
    end
    else
    begin
      rp_state <= next_rp_state;
      stretch <= (next_rp_state == RP_HOLD) ? stretch + 1'b1 : '0;
      reset_pin_oe <= (next_rp_state != RP_IDLE);
      reset_pin_out <= 1'b0;
      rp_s1 <= reset_pin_in;
      rp_s2 <= rp_s1;
      // our own low still sits in the synchroniser for two edges after release
      own_drive_d1 <= reset_pin_oe;
      own_drive_d2 <= own_drive_d1;
      // external low resets, not our own drive
      ext_reset_req <= ~rp_s2 & (rp_state == RP_IDLE) & ~reset_pin_oe & ~own_drive_d1
        & ~own_drive_d2;
    end
  end

  // async capture: pin itself clocks the request flop
  logic irq_latch;
  logic irq_clr;
  assign irq_clr = ~rst_n | (irq_ack & rq_s3);
  always_ff @(negedge irq_pin_n or posedge irq_clr)
  begin
    if (irq_clr)
      irq_latch <= 1'b0;
    else
      irq_latch <= 1'b1;
  end
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rq_s1 <= 1'b0;
      rq_s2 <= 1'b0;
      rq_s3 <= 1'b0;
      irq_pending <= 1'b0;
    end
    else
    begin
      rq_s1 <= irq_latch;
      rq_s2 <= rq_s1;
      rq_s3 <= rq_s2;
      irq_pending <= rq_s2;
    end
  end

  AST_RST_DRIVE: assert property (@(posedge mclk) disable iff (!rst_n)
    internal_reset_req |=> reset_pin_oe && !reset_pin_out) else $error("reset pin not driven");
  AST_RST_RELEASE: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(internal_reset_req) ##1 !internal_reset_req [*4] |=> !reset_pin_oe) else $error("no release");
  AST_EXT_RST: assert property (@(posedge mclk) disable iff (!rst_n)
    (!reset_pin_in && !reset_pin_oe && rp_state == RP_IDLE && !internal_reset_req) [*4]
    |-> ext_reset_req) else $error("external reset missed");
  AST_KBD_MASK: assert property (@(posedge mclk) disable iff (!rst_n)
    (keypad_wakeup_module_in & ~$past(keypad_wakeup_en)) == '0) else $error("keypad leak");
  AST_ANALOG_IN: assert property (@(posedge mclk) disable iff (!rst_n)
    conv_analog_en[0] |=> !converter_port_pins_oe[0]) else $error("analog pin driven");
  AST_SPI_OWN: assert property (@(posedge mclk) disable iff (!rst_n)
    spi_en |=> peripheral_port_pins_oe[3:0] == $past(spi_oe)) else $error("spi lost pins");
  AST_TIM_SEL: assert property (@(posedge mclk) disable iff (!rst_n)
    timer_ch_en[0] && timer_unit_sel[0] |=> peripheral_port_pins_out[4] ==
    $past(second_timer_unit_out[0])) else $error("timer mux wrong");
  AST_TX: assert property (@(posedge mclk) disable iff (!rst_n)
    serial_en |=> serial_port_pins_oe[0] && serial_port_pins_out[0] == $past(async_tx)
    && !serial_port_pins_oe[1]) else $error("serial pins wrong");
  // latched request shows in three cycles
  AST_IRQ: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(irq_latch) |-> ##[1:3] irq_pending) else $error("irq lost");
  AST_PU_BIT: assert property (@(posedge mclk) disable iff (!rst_n)
    keypad_pullup_sel[1] && !keypad_dir[1] |=> keypad_pullup_en[1]) else $error("pullup");
endmodule

// File: tb/board_port.sv
`timescale 1ns/1ps
// board side of one port: external drivers, pullups and floating lines
module board_port #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] pu_on,
  input wire logic [W-1:0] ext_en,
  input wire logic [W-1:0] ext_val,
  output logic [W-1:0] pin
);
  logic [W-1:0] float_pat = '0;
  // an undriven line without pullup wanders every cycle
  always_ff @(posedge mclk)
  begin
    float_pat <= ~float_pat;
  end
  // pin level from device, board driver, pullup or float
  assign pin = (oe & out) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & (pu_on | float_pat));
endmodule

// reset line with its pullup; the board may pull it low
module board_reset (
  input wire logic rst_out,
  input wire logic rst_oe,
  input wire logic ext_low,
  output logic rst_pin
);
  assign rst_pin = rst_oe ? rst_out : ~ext_low;
endmodule

// File: tb/test_port_pin_function_control.sv
`timescale 1ns/1ps
`define CHK(g, e, s) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("FAIL t=%0t out %0d got %h exp %h", $time, s, g, e); end end
module test_port_pin_function_control;
  import pin_ctrl_pkg::*;
  typedef struct {int sel; logic [7:0] exp; logic [7:0] mask;} note_t;
  note_t notes[$];
  event result_ev;
  int fail_count = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'h844b5d79;
  logic mclk = 0;
  logic rst_n = 0;
  logic spi_en, serial_en, async_tx, internal_reset_req, irq_pin_n, irq_ack, ext_low, async_rx;
  logic reset_pin_in, reset_pin_out, reset_pin_oe, ext_reset_req, irq_pending;
  logic [3:0] spi_oe, spi_out, timer_ch_en, timer_unit_sel;
  logic [1:0] first_timer_unit_oe, first_timer_unit_out, second_timer_unit_oe;
  logic [1:0] second_timer_unit_out;
  logic [7:0] keypad_dir, keypad_data, keypad_pullup_sel, keypad_wakeup_en, keypad_port_pins_in;
  logic [7:0] keypad_port_pins_out, keypad_port_pins_oe, keypad_pullup_en, keypad_port_value;
  logic [7:0] keypad_wakeup_module_in, conv_dir, conv_data, conv_analog_en, converter_port_pins_in;
  logic [7:0] converter_port_pins_out, converter_port_pins_oe, conv_digital_in_en, conv_port_value;
  logic [7:0] periph_dir, periph_data, periph_pullup_sel, peripheral_port_pins_in, kp_een, kp_ev;
  logic [7:0] peripheral_port_pins_out, peripheral_port_pins_oe, periph_pullup_en, periph_port_value;
  logic [6:0] drive_dir, drive_data, drive_pullup_sel, high_drive_port_pins_in, drive_port_value;
  logic [6:0] high_drive_port_pins_out, high_drive_port_pins_oe, drive_pullup_en;
  logic [5:0] serial_dir, serial_data, serial_port_pins_in, serial_port_pins_out, sp_een, sp_ev;
  logic [5:0] serial_port_pins_oe, serial_port_value;

  port_pin_function_control dut (.mclk, .rst_n, .keypad_dir, .keypad_data, .keypad_pullup_sel,
    .keypad_wakeup_en, .keypad_port_pins_in, .keypad_port_pins_out, .keypad_port_pins_oe,
    .keypad_pullup_en, .keypad_port_value, .keypad_wakeup_module_in, .conv_dir, .conv_data,
    .conv_analog_en, .converter_port_pins_in, .converter_port_pins_out, .converter_port_pins_oe,
    .conv_digital_in_en, .conv_port_value, .drive_dir, .drive_data, .drive_pullup_sel,
    .high_drive_port_pins_in, .high_drive_port_pins_out, .high_drive_port_pins_oe,
    .drive_pullup_en, .drive_port_value, .periph_dir, .periph_data, .periph_pullup_sel, .spi_en,
    .spi_oe, .spi_out, .timer_ch_en, .timer_unit_sel, .first_timer_unit_oe, .first_timer_unit_out,
    .second_timer_unit_oe, .second_timer_unit_out, .peripheral_port_pins_in,
    .peripheral_port_pins_out, .peripheral_port_pins_oe, .periph_pullup_en, .periph_port_value,
    .serial_dir, .serial_data, .serial_en, .async_tx, .serial_port_pins_in, .serial_port_pins_out,
    .serial_port_pins_oe, .serial_port_value, .async_rx, .internal_reset_req, .reset_pin_in,
    .reset_pin_out, .reset_pin_oe, .ext_reset_req, .irq_pin_n, .irq_ack, .irq_pending);
  board_port #(.W(8)) kp_board (.mclk, .out(keypad_port_pins_out), .oe(keypad_port_pins_oe),
    .pu_on(keypad_pullup_en), .ext_en(kp_een), .ext_val(kp_ev), .pin(keypad_port_pins_in));
  board_port #(.W(6)) sp_board (.mclk, .out(serial_port_pins_out), .oe(serial_port_pins_oe),
    .pu_on(6'h00), .ext_en(sp_een), .ext_val(sp_ev), .pin(serial_port_pins_in));
  board_reset rst_board (.rst_out(reset_pin_out), .rst_oe(reset_pin_oe), .ext_low,
    .rst_pin(reset_pin_in));

  // bus clock
  always #4 mclk = ~mclk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // observed output chosen by a note
  function automatic logic [7:0] get_out(int s);
    case (s)
      0: return keypad_port_pins_oe;
      1: return keypad_port_pins_out;
      2: return keypad_pullup_en;
      3: return keypad_wakeup_module_in;
      4: return keypad_port_value;
      5: return converter_port_pins_oe;
      6: return conv_digital_in_en;
      7: return {1'b0, high_drive_port_pins_oe};
      8: return {1'b0, drive_pullup_en};
      9: return peripheral_port_pins_oe;
      10: return peripheral_port_pins_out;
      11: return periph_pullup_en;
      12: return {2'b00, serial_port_pins_oe};
      13: return {2'b00, serial_port_pins_out};
      14: return {7'h00, async_rx};
      15: return {6'h00, reset_pin_out, reset_pin_oe};
      16: return {7'h00, ext_reset_req};
      17: return {7'h00, irq_pending};
      18: return converter_port_pins_out;
      19: return conv_port_value;
      20: return {1'b0, high_drive_port_pins_out};
      21: return {1'b0, drive_port_value};
      22: return periph_port_value;
      23: return {2'b00, serial_port_value};
      default: return 8'h00;
    endcase
  endfunction

  task automatic note(int s, logic [7:0] e, logic [7:0] m = 8'hff);
    notes.push_back('{s, e, m});
  endtask

  task automatic wait_n(int n);
    repeat (n) @(negedge mclk);
  endtask

  // watcher: takes every note off the queue, oldest first, and compares each
  always @(result_ev)
  begin
    note_t n;
    while (notes.size() > 0)
    begin
      n = notes.pop_front();
      `CHK(get_out(n.sel) & n.mask, n.exp & n.mask, n.sel)
    end
  end

  // all port controls, zero or random
  task automatic set_all(bit zero);
    {keypad_dir, keypad_data, keypad_pullup_sel, keypad_wakeup_en} = zero ? '0 : rnd();
    {conv_dir, conv_data, conv_analog_en, converter_port_pins_in} = zero ? '0 : rnd();
    {drive_dir, drive_data, drive_pullup_sel, high_drive_port_pins_in} = zero ? '0 : 28'(rnd());
    {periph_dir, periph_data, periph_pullup_sel, peripheral_port_pins_in} = zero ? '0 : rnd();
    {spi_en, spi_oe, spi_out, timer_ch_en, timer_unit_sel, first_timer_unit_oe,
      first_timer_unit_out, second_timer_unit_oe, second_timer_unit_out} = zero ? '0 : 25'(rnd());
    {serial_dir, serial_data, serial_en, async_tx, sp_een, sp_ev} = zero ? '0 : 26'(rnd());
    {kp_een, kp_ev} = zero ? '0 : 16'(rnd());
  endtask

  // random routing pass with expectations from the pin rules
  task automatic rand_pass();
    logic [7:0] pe_oe, pe_out, kknown, kval;
    logic [5:0] so_oe, so_out;
    set_all(0);
    pe_oe = periph_dir;
    pe_out = periph_data;
    if (spi_en)
    begin
      pe_oe[3:0] = spi_oe;
      pe_out[3:0] = spi_out;
    end
    for (int i = 0; i < 4; i++)
      if (timer_ch_en[i])
      begin
        pe_oe[i+4] = timer_unit_sel[i] ? second_timer_unit_oe[i%2] : first_timer_unit_oe[i%2];
        pe_out[i+4] = timer_unit_sel[i] ? second_timer_unit_out[i%2] : first_timer_unit_out[i%2];
      end
    so_oe = {serial_dir[5:2], ~serial_en & serial_dir[1], serial_en | serial_dir[0]};
    so_out = {serial_data[5:1], serial_en ? async_tx : serial_data[0]};
    kknown = keypad_dir | kp_een | keypad_pullup_sel;
    kval = (keypad_dir & keypad_data) | (~keypad_dir & kp_een & kp_ev) | (~keypad_dir & ~kp_een);
    wait_n(5);
    note(0, keypad_dir);
    note(1, keypad_data, keypad_dir);
    note(2, keypad_pullup_sel & ~keypad_dir);
    note(3, kval, kknown & keypad_wakeup_en);
    note(4, kval, kknown);
    note(5, conv_dir & ~conv_analog_en);
    note(6, ~conv_analog_en);
    note(7, {1'b0, drive_dir});
    note(8, {1'b0, drive_pullup_sel & ~drive_dir});
    note(9, pe_oe);
    note(10, pe_out, pe_oe);
    note(11, periph_pullup_sel & ~pe_oe);
    note(12, {2'b00, so_oe});
    note(13, {2'b00, so_out}, 8'(so_oe));
    note(14, {7'h00, ~serial_en | sp_ev[1]}, {7'h00, ~serial_en | sp_een[1]});
    note(18, conv_data, conv_dir & ~conv_analog_en);
    note(19, converter_port_pins_in);
    note(20, {1'b0, drive_data}, {1'b0, drive_dir});
    note(21, {1'b0, high_drive_port_pins_in});
    note(22, peripheral_port_pins_in);
    note(23, {2'b00, (so_oe & so_out) | (~so_oe & sp_ev)}, {2'b00, so_oe | sp_een});
    -> result_ev;
  endtask

  // main sequence
  initial
  begin
    set_all(1);
    {internal_reset_req, irq_ack, ext_low, irq_pin_n} = 4'h1;
    wait_n(7);
    note(0, 8'h00);
    note(6, 8'hff);
    note(14, 8'h01);
    note(15, 8'h00);
    note(17, 8'h00);
    -> result_ev;
    wait_n(1);
    rst_n = 1;
    $display("test reset values done");
    repeat (40) rand_pass();
    $display("test pin routing done");
    internal_reset_req = 1;
    wait_n(2);
    note(15, 8'h01);
    -> result_ev;
    wait_n(3);
    internal_reset_req = 0;
    wait_n(3);
    note(15, 8'h01);
    note(16, 8'h00);
    -> result_ev;
    wait_n(2);
    note(15, 8'h00);
    note(16, 8'h00);
    -> result_ev;
    wait_n(1);
    note(16, 8'h00);
    -> result_ev;
    wait_n(2);
    ext_low = 1;
    wait_n(6);
    note(16, 8'h01);
    -> result_ev;
    ext_low = 0;
    wait_n(6);
    note(16, 8'h00);
    -> result_ev;
    $display("test reset pin done");
    irq_pin_n = 0;
    wait_n(4);
    note(17, 8'h01);
    -> result_ev;
    irq_pin_n = 1;
    irq_ack = 1;
    wait_n(5);
    note(17, 8'h00);
    -> result_ev;
    irq_ack = 0;
    wait_n(2);
    $display("test interrupt pin done");
    print_verdict();
  end

  // watchdog against a hang
  initial
  begin
    #50000;
    fail_count++;
    print_verdict();
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
endmodule
